// >>> logic/igc_defines.svh
// Constants for the general call aware start generator
`ifndef IGC_DEFINES_SVH
`define IGC_DEFINES_SVH
`define IGC_MODE_MASTER 4'h8
`define IGC_MODE_SL7    4'h6
`define IGC_MODE_SL10   4'h7
`define IGC_GC_EN_BIT    7
`define IGC_START_EN_BIT 0
`define IGC_LOW5_MASK   8'h1F
`define IGC_GC_ADDR     8'h00
`define IGC_TEN_HI      5'h1E
`define IGC_CTL2_RST    8'h00
`define IGC_BYTE_BITS   4'h8
`define IGC_ACK_BIT     4'h9
`endif

// >>> logic/igc_pkg.sv
// Types shared by the general call aware start generator
package igc_pkg;
   typedef enum logic [3:0] {
      IGC_IDLE  = 4'b0001,
      IGC_SETUP = 4'b0010,
      IGC_HOLD  = 4'b0100,
      IGC_OWN   = 4'b1000
   } igc_mst_t;
endpackage

// >>> logic/igc_master.sv
// Receive FIFO and the serial port core: general call, start, baud generator
// What this block does
// - General call matches only with enable bit set
// - Compare address byte to own and all-zero
// - General call loads buffer, flag at ninth
// - Ten-bit general call needs no second byte
// - Slave events wake sleeping processor if enabled
// - Reset disables port and aborts transfer
// - Start and stop flags clear on disable
// - Master events raise port interrupt flag
// - Stop raises the interrupt in master mode, or after a seen start with IRQ_EN_I set
// - Data line mismatch sets bus collision
// - Mode field and enable select master
// - Master drives only data low for start, never clock
// - Buffer write during start is dropped, flagged
// - Low five control bits locked during start
// - Reload from seven low address bits
// - Count down twice per cycle, then halt
// - Reload only with clock line high
// - Start-enable loads generator, then data low
// - Second timeout ends start, raises flag
// - Collision during start aborts to idle
// - Read clears full; overflow cleared by write
`timescale 1ns/1ps
`include "igc_defines.svh"

// ----------------------------------------
// Receive FIFO
// ----------------------------------------
module igc_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   // Clock, reset and flush
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         clr_i,
   // Write side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // Read side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0]  mem_r [D];     // Storage words
   logic [AW-1:0] wp_r;          // Write index
   logic [AW-1:0] rp_r;          // Read index
   logic [AW:0]   cnt_r;         // Fill level
   logic          push;
   logic          pop;
   assign in_ready_o  = (cnt_r != (AW+1)'(D));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o  = mem_r[rp_r];
   assign push = in_valid_i & in_ready_o;
   assign pop  = out_valid_o & out_ready_i;
   // Word store
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wp_r] <= in_data_i;
      end
   end
   // Pointers and level
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else if (clr_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // igc_fifo

// ----------------------------------------
// Serial port core
// ----------------------------------------
module igc_master #(
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset
   input  wire logic       MCLK_I,
   input  wire logic       RST_N_I,
   // Two-wire bus, open drain
   input  wire logic       SCL_I,
   output logic            SCL_O,
   output logic            SCL_OE_O,
   input  wire logic       SDA_I,
   output logic            SDA_O,
   output logic            SDA_OE_O,
   // Configuration
   input  wire logic       PORT_EN_I,
   input  wire logic [3:0] MODE_SEL_I,
   input  wire logic       IRQ_EN_I,
   input  wire logic       SLEEP_I,
   input  wire logic       ADDR_WR_I,
   input  wire logic [7:0] ADDR_WDATA_I,
   input  wire logic       CTL2_WR_I,
   input  wire logic [7:0] CTL2_WDATA_I,
   // Buffer access
   input  wire logic       BUF_WR_I,
   input  wire logic [7:0] BUF_WDATA_I,
   input  wire logic       BUF_RD_I,
   // Flag clears
   input  wire logic       IRQ_CLR_I,
   input  wire logic       OV_CLR_I,
   input  wire logic       BCOL_CLR_I,
   input  wire logic       WR_COLL_CLR_I,
   // Status
   output logic [7:0]      BUF_O,
   output logic [7:0]      CTL2_O,
   output logic            BUF_FULL_O,
   output logic            OVERFLOW_O,
   output logic            UPD_ADDR_O,
   output logic            START_SEEN_O,
   output logic            STOP_SEEN_O,
   output logic            PORT_IRQ_O,
   output logic            BUS_COLL_O,
   output logic            WR_COLL_O,
   output logic            WAKE_O
);
   import igc_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   igc_mst_t    st_r;            // Start sequencer
   logic [7:0]  addr_r;          // Address or baud reload
   logic [7:0]  ctl2_r;          // Control two
   logic [7:0]  buf_r;           // Data buffer
   logic        full_r, ov_r, upd_r, s_r, p_r, irq_r, bcol_r, wr_coll_r, wake_r;
   logic        scl_q, sda_q;    // Previous bus levels
   logic        tick_r;          // Quarter-phase divider
   logic [6:0]  baud_r;          // Baud down-counter
   logic        baud_run_r;
   logic        hold_ld_r;       // Reload done in hold
   logic        sda_oe_r;
   logic [3:0]  sl_cnt_r;        // Slave bit count
   logic [7:0]  sl_sr_r;         // Serial shift register
   logic        sl_first_r, sl_ph2_r, sl_adr_r, sl_hit_r, sl_ack_r;
   logic        en, master, slave, ten, busy, tick, tout;
   logic        start_det, stop_det, scl_rise, scl_fall;
   logic        baud_load, coll, start_clr, m_irq, byte_done;
   logic        gc_hit, own_hit, ten_hi, ph2_hit, hit, f_valid, f_ready;
   logic        q_valid, q_take;
   logic [7:0]  q_data;
   logic        s_irq, irq_set;

   assign en      = PORT_EN_I;
   assign master  = en & (MODE_SEL_I == `IGC_MODE_MASTER);
   assign ten     = (MODE_SEL_I == `IGC_MODE_SL10);
   assign slave   = en & ((MODE_SEL_I == `IGC_MODE_SL7) | ten);
   assign busy    = (st_r == IGC_SETUP) | (st_r == IGC_HOLD);
   assign tick    = tick_r;
   assign tout    = baud_run_r & tick & (baud_r == 7'h00);
   assign scl_rise  = SCL_I & ~scl_q;
   assign scl_fall  = ~SCL_I & scl_q;
   assign start_det = SCL_I & scl_q & sda_q & ~SDA_I;
   assign stop_det  = SCL_I & scl_q & ~sda_q & SDA_I;

   // ----------------------------------------
   // Bus edge history
   // ----------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= SCL_I;
         sda_q <= SDA_I;
      end
   end

   // ----------------------------------------
   // Baud generator
   // ----------------------------------------
   // Tick on every second clock, Q2 and Q4
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         tick_r <= 1'b0;
      end else begin
         tick_r <= en & ~tick_r;
      end
   end

   // Down-count to zero, then halt
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         baud_r     <= 7'h00;
         baud_run_r <= 1'b0;
      end else if (!en) begin
         baud_r     <= 7'h00;
         baud_run_r <= 1'b0;
      end else if (baud_load) begin
         baud_r     <= addr_r[6:0];
         baud_run_r <= 1'b1;
      end else if (tout) begin
         baud_run_r <= 1'b0;
      end else if (baud_run_r & tick) begin
         baud_r <= baud_r - 7'h01;
      end
   end

   // ----------------------------------------
   // Start sequencer
   // ----------------------------------------
   always_comb begin
      baud_load = 1'b0;
      coll      = 1'b0;
      start_clr = 1'b0;
      m_irq     = 1'b0;
      unique case (st_r)
         IGC_IDLE: begin
            if (master & ctl2_r[`IGC_START_EN_BIT]) begin
               if (SDA_I & SCL_I & (p_r | ~s_r)) begin
                  baud_load = 1'b1;
               end else begin
                  coll      = 1'b1;
                  start_clr = 1'b1;
               end
            end
         end
         IGC_SETUP: begin
            if (!SCL_I | (tout & !SDA_I)) begin
               coll      = 1'b1;
               start_clr = 1'b1;
            end
         end
         IGC_HOLD: begin
            baud_load = s_r & !hold_ld_r & SCL_I;
            if (tout & hold_ld_r) begin
               start_clr = 1'b1;
               m_irq   = 1'b1;
            end
         end
         IGC_OWN: begin
         end
      endcase
      coll = coll | (busy & SCL_I & ~sda_oe_r & ~SDA_I);
   end

   // State moves; disable aborts everything
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_r      <= IGC_IDLE;
         hold_ld_r <= 1'b0;
      end else if (!master) begin
         st_r      <= IGC_IDLE;
         hold_ld_r <= 1'b0;
      end else if (coll) begin
         st_r      <= IGC_IDLE;
         hold_ld_r <= 1'b0;
      end else begin
         unique case (st_r)
            IGC_IDLE: begin
               if (baud_load) begin
                  st_r <= IGC_SETUP;
               end
            end
            IGC_SETUP: begin
               if (tout) begin
                  st_r <= IGC_HOLD;
               end
            end
            IGC_HOLD: begin
               if (baud_load) begin
                  hold_ld_r <= 1'b1;
               end
               if (start_clr) begin
                  st_r      <= IGC_OWN;
                  hold_ld_r <= 1'b0;
               end
            end
            IGC_OWN: begin
            end
         endcase
      end
   end

   // Data line drive: start hold or slave acknowledge
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sda_oe_r <= 1'b0;
      end else begin
         sda_oe_r <= (master & !coll & (((st_r == IGC_SETUP) & tout) |
                     (st_r == IGC_HOLD) | (st_r == IGC_OWN))) |
                     (slave & sl_ack_r);
      end
   end
   assign SDA_O    = 1'b0;
   assign SCL_O    = 1'b0;
   assign SCL_OE_O = 1'b0;
   assign SDA_OE_O = sda_oe_r;

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   // Address or baud reload
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         addr_r <= 8'h00;
      end else if (ADDR_WR_I) begin
         addr_r <= ADDR_WDATA_I;
      end
   end

   // Control two; low bits locked while start runs
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ctl2_r <= `IGC_CTL2_RST;
      end else if (!en) begin
         ctl2_r <= ctl2_r & ~`IGC_LOW5_MASK;
      end else begin
         if (CTL2_WR_I) begin
            ctl2_r <= busy ? ((CTL2_WDATA_I & ~`IGC_LOW5_MASK) |
                              (ctl2_r & `IGC_LOW5_MASK))
                           : CTL2_WDATA_I;
         end
         if (start_clr) begin
            ctl2_r[`IGC_START_EN_BIT] <= 1'b0;
         end
      end
   end

   // Data buffer: FIFO head loads when empty
   assign q_take = q_valid & !full_r;
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         buf_r  <= 8'h00;
         full_r <= 1'b0;
      end else if (!en) begin
         full_r <= 1'b0;
      end else if (q_take) begin
         buf_r  <= q_data;
         full_r <= 1'b1;
      end else begin
         if (BUF_WR_I & !busy) begin
            buf_r <= BUF_WDATA_I;
         end
         if (BUF_RD_I) begin
            full_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Flags, set wins over clear
   // ----------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         bcol_r    <= 1'b0;
         wr_coll_r <= 1'b0;
      end else begin
         bcol_r    <= coll | (bcol_r & ~BCOL_CLR_I);
         wr_coll_r <= (BUF_WR_I & busy) | (wr_coll_r & ~WR_COLL_CLR_I);
      end
   end

   // Bus start and stop seen
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s_r <= 1'b0;
         p_r <= 1'b0;
      end else if (!en) begin
         s_r <= 1'b0;
         p_r <= 1'b0;
      end else if (start_det) begin
         s_r <= 1'b1;
         p_r <= 1'b0;
      end else if (stop_det) begin
         s_r <= 1'b0;
         p_r <= 1'b1;
      end
   end

   // Port interrupt flag and wake
   assign irq_set = m_irq | s_irq |
                    (stop_det & (master | (s_r & IRQ_EN_I)));
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         irq_r  <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         irq_r  <= irq_set | (irq_r & ~IRQ_CLR_I);
         wake_r <= SLEEP_I & IRQ_EN_I & s_irq;
      end
   end

   // ----------------------------------------
   // Slave receiver
   // ----------------------------------------
   assign byte_done = slave & scl_fall & (sl_cnt_r == `IGC_BYTE_BITS);
   assign gc_hit  = ctl2_r[`IGC_GC_EN_BIT] & (sl_sr_r == `IGC_GC_ADDR);
   assign own_hit = !ten & (sl_sr_r[7:1] == addr_r[7:1]);
   assign ten_hi  = ten & (sl_sr_r[7:3] == `IGC_TEN_HI) &
                    (sl_sr_r[2:1] == addr_r[2:1]) & !sl_sr_r[0];
   assign ph2_hit = sl_ph2_r & (sl_sr_r == addr_r);
   assign hit = sl_adr_r | (sl_first_r & (gc_hit | own_hit | ten_hi)) | ph2_hit;
   assign f_valid = byte_done & hit & !ov_r;
   assign s_irq = slave & scl_fall & (sl_cnt_r == `IGC_ACK_BIT) & sl_hit_r;

   // Shift, compare, acknowledge
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sl_cnt_r   <= 4'h0;
         sl_sr_r    <= 8'h00;
         sl_first_r <= 1'b0;
         sl_ph2_r   <= 1'b0;
         sl_adr_r   <= 1'b0;
         sl_hit_r   <= 1'b0;
         sl_ack_r   <= 1'b0;
      end else if (!slave | stop_det) begin
         sl_cnt_r   <= 4'h0;
         sl_first_r <= 1'b0;
         sl_ph2_r   <= 1'b0;
         sl_adr_r   <= 1'b0;
         sl_ack_r   <= 1'b0;
      end else if (start_det) begin
         sl_cnt_r   <= 4'h0;
         sl_first_r <= 1'b1;
         sl_ph2_r   <= 1'b0;
         sl_adr_r   <= 1'b0;
         sl_ack_r   <= 1'b0;
      end else if (scl_rise & (sl_cnt_r < `IGC_BYTE_BITS)) begin
         sl_sr_r  <= {sl_sr_r[6:0], SDA_I};
         sl_cnt_r <= sl_cnt_r + 4'h1;
      end else if (byte_done) begin
         sl_cnt_r   <= `IGC_ACK_BIT;
         sl_hit_r   <= hit;
         sl_ack_r   <= hit & f_ready & !ov_r;
         sl_first_r <= 1'b0;
         sl_ph2_r   <= sl_first_r & ten_hi & !gc_hit;
         sl_adr_r   <= sl_adr_r | (sl_first_r & (gc_hit | own_hit)) | ph2_hit;
      end else if (scl_fall & (sl_cnt_r == `IGC_ACK_BIT)) begin
         sl_cnt_r <= 4'h0;
         sl_ack_r <= 1'b0;
         sl_hit_r <= 1'b0;
      end
   end

   // Overflow and update-address
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ov_r  <= 1'b0;
         upd_r <= 1'b0;
      end else begin
         ov_r  <= (byte_done & hit & !f_ready) | (ov_r & ~OV_CLR_I);
         upd_r <= (byte_done & ((sl_first_r & ten_hi & !gc_hit) | ph2_hit)) |
                  (upd_r & ~ADDR_WR_I & en);
      end
   end

   igc_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
      .clk_i       (MCLK_I),
      .rst_n_i     (RST_N_I),
      .clr_i       (!en),
      .in_valid_i  (f_valid),
      .in_ready_o  (f_ready),
      .in_data_i   (sl_sr_r),
      .out_valid_o (q_valid),
      .out_ready_i (!full_r),
      .out_data_o  (q_data)
   );

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign BUF_O        = buf_r;
   assign CTL2_O       = ctl2_r;
   assign BUF_FULL_O   = full_r;
   assign OVERFLOW_O   = ov_r;
   assign UPD_ADDR_O   = upd_r;
   assign START_SEEN_O = s_r;
   assign STOP_SEEN_O  = p_r;
   assign PORT_IRQ_O   = irq_r;
   assign BUS_COLL_O   = bcol_r;
   assign WR_COLL_O    = wr_coll_r;
   assign WAKE_O       = wake_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_gc_gate: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (byte_done & sl_first_r & (sl_sr_r == 8'h00) & !ctl2_r[7] & !ten) |-> !hit)
      else $error("general call matched with enable clear");
   a_start_drive: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (master & st_r == IGC_SETUP & tout & SDA_I & SCL_I) |=> (SDA_OE_O & st_r == IGC_HOLD))
      else $error("data not driven low at start timeout");
   a_start_end: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (master & st_r == IGC_HOLD & tout & hold_ld_r & !coll)
      |=> (!CTL2_O[0] & PORT_IRQ_O & SDA_OE_O & st_r == IGC_OWN))
      else $error("start completion effects missing");
   a_write_drop: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (BUF_WR_I & busy & !q_take) |=> (WR_COLL_O & $stable(BUF_O)))
      else $error("buffer write during start not dropped");
   a_low5_lock: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (CTL2_WR_I & busy & en & !start_clr) |=> (CTL2_O[4:0] == $past(CTL2_O[4:0])))
      else $error("low control bits changed during start");
   a_flags_off: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      !PORT_EN_I |=> (!START_SEEN_O & !STOP_SEEN_O))
      else $error("start or stop flag survived disable");
   a_baud_reload: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (baud_load & master) |-> SCL_I)
      else $error("baud reload with clock low");
   a_baud_halt: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (tout & !baud_load) |=> (!baud_run_r ##1 $stable(baud_r)))
      else $error("baud generator did not halt at zero");
   a_coll_abort: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (master & st_r == IGC_SETUP & !SCL_I) |=> (BUS_COLL_O & st_r == IGC_IDLE & !CTL2_O[0]))
      else $error("clock low during start not flagged");
   a_bcol_sticky: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      (BUS_COLL_O & !BCOL_CLR_I) |=> BUS_COLL_O)
      else $error("collision flag cleared without software");
endmodule // igc_master

// >>> sim/igc_bus_peer.sv
// Behavioural model of another party on the two-wire bus
`timescale 1ns/1ps
// ------------------------------
// Bus peer
// ------------------------------
module igc_bus_peer (
   // Clock
   input  wire logic clk_i,
   // Pulls, high drives the line low
   output logic      scl_pull_o,
   output logic      sda_pull_o,
   // Resolved data line
   input  wire logic sda_i
);
   localparam int HALF = 8;  // Half bit time in core clocks
   initial begin
      scl_pull_o = 1'b0;
      sda_pull_o = 1'b0;
   end
   // Wait core clock edges
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   // Hold clock low, as a rival party
   task automatic pull_clock(input logic v);
      scl_pull_o <= v;
   endtask
   // Start only from an idle bus
   task automatic frame_start();
      sda_pull_o <= 1'b1;
      tick(HALF);
      scl_pull_o <= 1'b1;
      tick(HALF);
   endtask
   // Data rises while clock is high
   task automatic frame_stop();
      sda_pull_o <= 1'b1;
      tick(HALF);
      scl_pull_o <= 1'b0;
      tick(HALF);
      sda_pull_o <= 1'b0;
      tick(HALF);
   endtask
   // Eight bits first high, then sample the ninth
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_pull_o <= ~b[i];
         tick(HALF);
         scl_pull_o <= 1'b0;
         tick(HALF);
         scl_pull_o <= 1'b1;
         tick(1);
      end
      sda_pull_o <= 1'b0;
      tick(HALF);
      scl_pull_o <= 1'b0;
      tick(HALF / 2);
      ack = ~sda_i;
      tick(HALF / 2);
      scl_pull_o <= 1'b1;
      tick(HALF);
   endtask
endmodule // igc_bus_peer

// >>> sim/tb_top.sv
// Self-checking bench for the serial port core
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
`define WAIT(c, lim) n = 0; while (!(c) && n < (lim)) begin @(negedge mclk); n++; end
// ------------------------------
// Bench top
// ------------------------------
module tb_top;
   logic       mclk = 1'b0, rst_n = 1'b0, en = 1'b0, irq_en = 1'b0, sleep = 1'b0;
   logic [3:0] mode = 4'h8;
   logic       a_wr = 1'b0, c_wr = 1'b0, b_wr = 1'b0, b_rd = 1'b0;
   logic [7:0] a_d = 8'h00, c_d = 8'h00, b_d = 8'h00;
   logic       i_clr = 1'b0, o_clr = 1'b0, bc_clr = 1'b0, wc_clr = 1'b0;
   logic       scl_oe, sda_oe, scl_pull, sda_pull, scl, sda, ack, wake_seen = 1'b0;
   logic [7:0] buf_q, ctl2_q;
   logic       full, ovf, upd, s_seen, p_seen, irq, bcol, wr_coll, wake;
   logic [7:0] seq [6] = '{8'h00, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
   int         bad_count = 0, cmp_count = 0, n;
   assign scl = ~(scl_oe | scl_pull);  // Pull-ups: released lines read high
   assign sda = ~(sda_oe | sda_pull);
   initial forever #20 mclk = ~mclk;
   always @(posedge mclk) if (wake === 1'b1) wake_seen <= 1'b1;
   igc_master #(.FIFO_DEPTH(4)) dut (
      .MCLK_I(mclk), .RST_N_I(rst_n), .SCL_I(scl), .SCL_O(), .SCL_OE_O(scl_oe),
      .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe), .PORT_EN_I(en), .MODE_SEL_I(mode),
      .IRQ_EN_I(irq_en), .SLEEP_I(sleep), .ADDR_WR_I(a_wr), .ADDR_WDATA_I(a_d),
      .CTL2_WR_I(c_wr), .CTL2_WDATA_I(c_d), .BUF_WR_I(b_wr), .BUF_WDATA_I(b_d),
      .BUF_RD_I(b_rd), .IRQ_CLR_I(i_clr), .OV_CLR_I(o_clr), .BCOL_CLR_I(bc_clr),
      .WR_COLL_CLR_I(wc_clr), .BUF_O(buf_q), .CTL2_O(ctl2_q), .BUF_FULL_O(full),
      .OVERFLOW_O(ovf), .UPD_ADDR_O(upd), .START_SEEN_O(s_seen), .STOP_SEEN_O(p_seen),
      .PORT_IRQ_O(irq), .BUS_COLL_O(bcol), .WR_COLL_O(wr_coll), .WAKE_O(wake));
   igc_bus_peer peer (.clk_i(mclk), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull),
      .sda_i(sda));
   // One-cycle strobe, taken at the rising edge between
   task automatic pulse(ref logic s);
      @(negedge mclk) s = 1'b1;
      @(negedge mclk) s = 1'b0;
   endtask
   // Register style write: data with its strobe
   task automatic wr(ref logic s, ref logic [7:0] d, input logic [7:0] v);
      @(negedge mclk) d = v;
      s = 1'b1;
      @(negedge mclk) s = 1'b0;
   endtask
   task automatic idle(input int k);
      repeat (k) @(negedge mclk);
   endtask
   // Counts, verdict and end of run
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (30000) @(posedge mclk);
      bad_count++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      idle(12);
      rst_n = 1'b1;
      idle(1);
      `CHK({ctl2_q, s_seen, p_seen, irq, sda_oe}, 12'h000)
      en = 1'b1;
      wr(a_wr, a_d, 8'h03);
      wr(c_wr, c_d, 8'h01);
      `WAIT(sda_oe === 1'b1, 40)
      `CHK(n >= 4 && n <= 12, 1'b1)
      wr(b_wr, b_d, 8'hAA);
      wr(c_wr, c_d, 8'hFE);
      `CHK(ctl2_q, 8'hE1)
      `WAIT(irq === 1'b1, 60)
      `CHK({ctl2_q, s_seen, sda_oe, wr_coll, buf_q}, {8'hE0, 3'b111, 8'h00})
      pulse(i_clr);
      pulse(wc_clr);
      `CHK({irq, wr_coll, sda_oe}, 3'b001)
      en = 1'b0;
      idle(2);
      `CHK({s_seen, sda_oe, ctl2_q}, {2'b00, 8'hE0})
      // Clock held low by a rival when the start begins
      en = 1'b1;
      peer.pull_clock(1'b1);
      wr(c_wr, c_d, 8'h01);
      idle(4);
      `CHK({bcol, ctl2_q[0], sda_oe}, 3'b100)
      peer.pull_clock(1'b0);
      idle(20);
      `CHK(bcol, 1'b1)
      pulse(bc_clr);
      `CHK(bcol, 1'b0)
      // Clock pulled low by a rival while the start is counting
      wr(c_wr, c_d, 8'h01);
      idle(2);
      peer.pull_clock(1'b1);
      idle(2);
      `CHK({bcol, ctl2_q[0], sda_oe, s_seen}, 4'h8)
      peer.pull_clock(1'b0);
      pulse(bc_clr);
      `CHK(bcol, 1'b0)
      // Seven-bit slave, asleep, general call enabled
      mode = 4'h6;
      irq_en = 1'b1;
      sleep = 1'b1;
      wr(a_wr, a_d, 8'h52);
      wr(c_wr, c_d, 8'h80);
      peer.frame_start();
      peer.send_byte(8'h00, ack);
      idle(4);
      `CHK({ack, buf_q, full, irq, wake_seen}, {1'b1, 8'h00, 3'b111})
      pulse(i_clr);
      peer.frame_stop();
      idle(4);
      `CHK({p_seen, irq}, 2'b11)
      pulse(b_rd);
      pulse(i_clr);
      `CHK(full, 1'b0)
      peer.frame_start();
      peer.send_byte(8'h52, ack);
      idle(4);
      `CHK({ack, buf_q}, 9'h152)
      peer.frame_stop();
      pulse(b_rd);
      pulse(i_clr);
      wr(c_wr, c_d, 8'h00);
      peer.frame_start();
      peer.send_byte(8'h00, ack);
      idle(4);
      `CHK({ack, irq}, 2'b00)
      peer.frame_stop();
      pulse(i_clr);
      // Ten-bit slave: general call, then data until the FIFO refuses
      mode = 4'h7;
      wr(c_wr, c_d, 8'h80);
      peer.frame_start();
      for (int i = 0; i < 6; i++) begin
         peer.send_byte(seq[i], ack);
         `CHK(ack, i < 5)
      end
      peer.frame_stop();
      idle(2);
      `CHK({upd, ovf}, 2'b01)
      for (int i = 0; i < 5; i++) begin
         `CHK(buf_q, seq[i])
         pulse(b_rd);
         idle(2);
      end
      `CHK({full, ovf}, 2'b01)
      pulse(o_clr);
      `CHK(ovf, 1'b0)
      tally_and_finish();
   end
endmodule // tb_top
